// ---- design/ihc_top.sv ----
`timescale 1ns/10ps
`include "ihc_regs.svh"
module ihc_top #(
  parameter int WARM_SHORT = `IHC_WARM_SHORT,
  parameter int WARM_LONG  = `IHC_WARM_LONG
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // internal register bus
  input  wire logic [15:0]       bus_addr,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [7:0]        bus_wdata,
  output logic      [7:0]        bus_rdata,
  // external request pins
  input  wire logic              nmi_pin,
  input  wire logic              ext_irq_first,
  input  wire logic              ext_irq_second,
  // peripheral request pulses
  input  wire logic              watchdog_irq,
  input  wire logic [3:0]        timer_irq,
  input  wire logic              spare_irq,
  input  wire logic              serial_rx_done_irq,
  input  wire logic              serial_tx_done_irq,
  input  wire logic              serial_rx_buf_read,
  // cpu side
  input  wire logic              global_irq_on,
  input  wire logic              cpu_ack,
  input  wire logic [7:0]        cpu_ack_vec,
  input  wire logic              halt_cmd,
  output ihc_pkg::ihc_chvec_t    pend_status,
  output ihc_pkg::ihc_chvec_t    dma_route,
  output logic                   irq_req,
  output logic                   nmi_req,
  // halt control
  output logic                   cpu_halted,
  output logic                   halt_release,
  output logic                   sysclk_all_en,
  output logic                   periph_clk_en,
  output logic                   wdog_clk_en,
  output logic                   osc_en,
  output logic                   clk_out_hold,
  output logic                   pins_float,
  output logic                   pins_hold
);
  import ihc_pkg::*;

  ihc_state_s s_reg;        // all controller state
  ihc_state_s s_next;
  logic       nmi_fall;     // nmi falling edge pulse
  logic       ext0_rise;    // first input rising pulse
  logic       ext1_rise;    // second input rising pulse
  ihc_chvec_t eff_pend;     // latches with level bypass applied
  ihc_chvec_t en_full;      // enables, nonmaskable forced on
  ihc_chvec_t req_vec;      // latched and enabled
  ihc_chvec_t wake_mask;    // sources allowed to end this halt
  logic       wake;         // halt release condition

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // vector/8 code to channel mask; unknown codes clear nothing
  function automatic ihc_chvec_t code_mask(input logic [7:0] code);
    ihc_chvec_t m;
    m = '0;
    if (code >= `IHC_VEC_FIRST && code <= `IHC_VEC_LINEAR) begin
      m[code[3:0] - 4'h3] = 1'b1;
    end else if (code == `IHC_VEC_RXD) begin
      m[`IHC_CH_RXD] = 1'b1;
    end else if (code == `IHC_VEC_TXD) begin
      m[`IHC_CH_TXD] = 1'b1;
    end
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // edge detectors

  ihc_edge_det #(.RISING(1'b0)) u_nmi (
    .clock (clock), .arst_n (arst_n), .ce (ce), .din (nmi_pin), .pulse (nmi_fall)
  );
  ihc_edge_det #(.RISING(1'b1)) u_ext0 (
    .clock (clock), .arst_n (arst_n), .ce (ce), .din (ext_irq_first), .pulse (ext0_rise)
  );
  ihc_edge_det #(.RISING(1'b1)) u_ext1 (
    .clock (clock), .arst_n (arst_n), .ce (ce), .din (ext_irq_second), .pulse (ext1_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // request qualification

  // level mode bypasses the latch; source must hold its level
  always_comb begin
    eff_pend = s_reg.pend;
    if (!s_reg.edge_sel) begin
      eff_pend[`IHC_CH_EXT0] = ext_irq_first;
    end
    en_full = s_reg.en;
    en_full[`IHC_CH_NMI]  = 1'b1;
    en_full[`IHC_CH_WDOG] = 1'b1;
  end

  assign req_vec     = eff_pend & en_full;
  // nonmaskable channels ignore the global enable
  assign nmi_req     = req_vec[`IHC_CH_NMI] | req_vec[`IHC_CH_WDOG];
  assign irq_req     = global_irq_on & (|req_vec[`IHC_NCH-1:`IHC_CH_EXT0]);
  assign pend_status = s_reg.pend;
  assign dma_route   = req_vec & s_reg.dma;

  // deep halts only hear nmi and the first external input
  always_comb begin
    wake_mask = '1;
    if (s_reg.hmode == HM_OSC || s_reg.hmode == HM_STOP) begin
      wake_mask = '0;
      wake_mask[`IHC_CH_NMI]  = 1'b1;
      wake_mask[`IHC_CH_EXT0] = 1'b1;
    end
  end
  // only an enabled request wakes, disabled maskable ones do not; flag is left alone
  assign wake = |(req_vec & wake_mask);

  //////////////////////////////////////////////////////////////////////////
  // halt decode outputs

  assign cpu_halted    = (s_reg.state != ST_RUN);
  assign halt_release  = s_reg.release_p;
  assign sysclk_all_en = (s_reg.state == ST_RUN) ||
                         (s_reg.state == ST_HALT && s_reg.hmode == HM_RUN);
  assign periph_clk_en = sysclk_all_en ||
                         (s_reg.state == ST_HALT && s_reg.hmode == HM_PERIPH);
  assign wdog_clk_en   = periph_clk_en ||
                         (s_reg.state == ST_HALT && s_reg.hmode == HM_OSC);
  assign osc_en        = !(s_reg.state == ST_HALT && s_reg.hmode == HM_STOP);
  assign clk_out_hold  = (s_reg.state == ST_WARM) || (s_reg.state == ST_HALT &&
                         (s_reg.hmode == HM_OSC || s_reg.hmode == HM_STOP));
  assign pins_float    = (s_reg.state != ST_RUN) && s_reg.hmode == HM_STOP &&
                         !s_reg.drive;
  assign pins_hold     = (s_reg.state != ST_RUN) && s_reg.hmode == HM_STOP &&
                         s_reg.drive;
  assign bus_rdata     = s_reg.rdata;

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    ihc_chvec_t set_v;
    ihc_chvec_t clr_v;
    s_next = s_reg;
    set_v  = '0;
    clr_v  = '0;
    if (ce) begin
      s_next.release_p = 1'b0;
      // request sources; watchdog gated off in oscillator-only halt
      set_v[`IHC_CH_NMI]  = nmi_fall;
      set_v[`IHC_CH_WDOG] = watchdog_irq &&
                            !(s_reg.state == ST_HALT && s_reg.hmode == HM_OSC);
      set_v[`IHC_CH_EXT0] = s_reg.edge_sel & ext0_rise;
      set_v[`IHC_CH_TMR3:`IHC_CH_TMR0] = timer_irq;
      set_v[`IHC_CH_SPARE] = spare_irq;
      set_v[`IHC_CH_EXT1]  = ext1_rise;
      set_v[`IHC_CH_RXD]   = serial_rx_done_irq;
      set_v[`IHC_CH_TXD]   = serial_tx_done_irq;
      // acknowledge with vector read clears that channel
      if (cpu_ack) begin
        clr_v = clr_v | code_mask(cpu_ack_vec);
      end
      // clear-by-write of vector/8
      if (bus_wr && bus_addr == `IHC_ADDR_STAT_CLR) begin
        clr_v = clr_v | code_mask(bus_wdata);
      end
      // receive flag only yields to a buffer read
      clr_v[`IHC_CH_RXD] = serial_rx_buf_read;
      // a new event wins over a clear in the same cycle
      s_next.pend = (s_reg.pend & ~clr_v) | set_v;
      if (!s_reg.edge_sel) begin
        // level mode: latch mirrors the pin, kept on switch back to edge
        s_next.pend[`IHC_CH_EXT0] = ext_irq_first;
      end

      // register writes
      if (bus_wr) begin
        unique case (bus_addr)
          `IHC_ADDR_PORT8_CTL: begin
            s_next.edge_sel = bus_wdata[`IHC_P8_EDGE];
            if (s_reg.edge_sel && !bus_wdata[`IHC_P8_EDGE]) begin
              s_next.pend[`IHC_CH_EXT0] = 1'b0;
            end
          end
          `IHC_ADDR_HALT_WD: begin
            s_next.drive   = bus_wdata[`IHC_HW_DRIVE];
            s_next.hmode   = ihc_hmode_e'(bus_wdata[`IHC_HW_MODE_LO +: 2]);
            s_next.warm    = bus_wdata[`IHC_HW_WARM];
            s_next.wd_bits = bus_wdata[`IHC_HW_WD_LO +: 3];
          end
          `IHC_ADDR_EN_LO: begin
            s_next.en[`IHC_CH_TMR3:`IHC_CH_EXT0] = {bus_wdata[3], bus_wdata[4],
              bus_wdata[5], bus_wdata[6], bus_wdata[7]};
            s_next.en[`IHC_CH_TXD:`IHC_CH_EXT1] = bus_wdata[2:0];
          end
          `IHC_ADDR_EN_DMA: begin
            s_next.en[`IHC_CH_SPARE]  = bus_wdata[0];
            s_next.dma[`IHC_CH_TMR0] = bus_wdata[7];
            s_next.dma[`IHC_CH_TMR1] = bus_wdata[6];
          end
          `IHC_ADDR_DMA_HI: begin
            s_next.dma[`IHC_CH_TXD] = bus_wdata[0];
            s_next.dma[`IHC_CH_RXD] = bus_wdata[1];
          end
          default: begin
            // unmapped or status-only address, nothing stored
          end
        endcase
      end

      // register reads, unmapped reads return zero
      if (bus_rd) begin
        unique case (bus_addr)
          `IHC_ADDR_STAT_LO: s_next.rdata = {1'b0, eff_pend[`IHC_CH_EXT0],
            eff_pend[`IHC_CH_TMR0], eff_pend[`IHC_CH_TMR1], 4'h0};
          `IHC_ADDR_STAT_CLR: s_next.rdata = {eff_pend[`IHC_CH_NMI],
            eff_pend[`IHC_CH_WDOG], eff_pend[`IHC_CH_TXD:`IHC_CH_EXT1],
            eff_pend[`IHC_CH_SPARE:`IHC_CH_TMR2]};
          `IHC_ADDR_PORT8_CTL: s_next.rdata = {7'h00, s_reg.edge_sel};
          `IHC_ADDR_HALT_WD: s_next.rdata = {s_reg.wd_bits, s_reg.warm,
            s_reg.hmode, 1'b0, s_reg.drive};
          `IHC_ADDR_EN_LO: s_next.rdata = {s_reg.en[`IHC_CH_EXT0], s_reg.en[`IHC_CH_TMR0],
            s_reg.en[`IHC_CH_TMR1], s_reg.en[`IHC_CH_TMR2], s_reg.en[`IHC_CH_TMR3],
            s_reg.en[`IHC_CH_TXD:`IHC_CH_EXT1]};
          `IHC_ADDR_EN_DMA: s_next.rdata = {s_reg.dma[`IHC_CH_TMR0],
            s_reg.dma[`IHC_CH_TMR1], 5'h00, s_reg.en[`IHC_CH_SPARE]};
          `IHC_ADDR_DMA_HI: s_next.rdata = {6'h00, s_reg.dma[`IHC_CH_RXD],
            s_reg.dma[`IHC_CH_TXD]};
          default: s_next.rdata = 8'h00;
        endcase
      end

      // halt sequencer
      unique case (s_reg.state)
        ST_RUN: begin
          if (halt_cmd) begin
            s_next.state = ST_HALT;
          end
        end
        ST_HALT: begin
          if (wake && s_reg.hmode == HM_STOP) begin
            // oscillator back at once, clock waits for warm-up
            s_next.state = ST_WARM;
            s_next.wcnt  = s_reg.warm ? WARM_LONG[`IHC_WCNT_W-1:0] - 1'b1
                                      : WARM_SHORT[`IHC_WCNT_W-1:0] - 1'b1;
          end else if (wake) begin
            // release lines up with the system clock
            s_next.state     = ST_RUN;
            s_next.release_p = 1'b1;
          end
        end
        ST_WARM: begin
          if (s_reg.wcnt == '0) begin
            s_next.state     = ST_RUN;
            s_next.release_p = 1'b1;
          end else begin
            s_next.wcnt = s_reg.wcnt - 1'b1;
          end
        end
        default: s_next.state = ST_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  // reset lands straight in run: no warm-up after a reset exit, and
  // memory outside this block is untouched by it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '{state: ST_RUN, hmode: HM_RUN, pend: '0, en: '0, dma: '0,
                 edge_sel: 1'b0, wd_bits: `IHC_HW_WD_RST, warm: 1'b0, drive: 1'b0,
                 wcnt: '0, release_p: 1'b0, rdata: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_write_clear_t1: assert property (ce && bus_wr && bus_addr == `IHC_ADDR_STAT_CLR
      && bus_wdata == 8'h07 && !timer_irq[1] |=> !s_reg.pend[`IHC_CH_TMR1])
    else $error("clear-by-write left timer one pending");
  a_rx_write_immune: assert property (ce && bus_wr && bus_addr == `IHC_ADDR_STAT_CLR
      && bus_wdata == `IHC_VEC_RXD && s_reg.pend[`IHC_CH_RXD] && !serial_rx_buf_read
      |=> s_reg.pend[`IHC_CH_RXD])
    else $error("write cleared serial receive flag");
  a_irq_needs_gie: assert property (irq_req |-> global_irq_on
      && |(s_reg.en & eff_pend))
    else $error("maskable request without enables");
  a_edge_to_level: assert property (ce && s_reg.edge_sel && bus_wr
      && bus_addr == `IHC_ADDR_PORT8_CTL && !bus_wdata[0]
      |=> !s_reg.pend[`IHC_CH_EXT0] && !s_reg.edge_sel)
    else $error("mode change did not clear first input flag");
  a_wdog_blocked: assert property (ce && s_reg.state == ST_HALT && s_reg.hmode == HM_OSC
      && !s_reg.pend[`IHC_CH_WDOG] && !(cpu_ack && bus_wr) |=> !s_reg.pend[`IHC_CH_WDOG])
    else $error("watchdog latched during oscillator-only halt");
  a_osc_clk_hold: assert property (s_reg.state == ST_HALT && s_reg.hmode == HM_OSC
      |-> clk_out_hold && !periph_clk_en && wdog_clk_en)
    else $error("clock output not held in oscillator-only halt");
  a_stop_warmup: assert property (ce && s_reg.state == ST_HALT && s_reg.hmode == HM_STOP
      && wake |=> s_reg.state == ST_WARM && !halt_release ##1 clk_out_hold)
    else $error("stop release skipped warm-up");
  a_periph_clk: assert property (s_reg.state == ST_HALT && s_reg.hmode == HM_PERIPH
      |-> periph_clk_en && !sysclk_all_en)
    else $error("peripheral halt clock gating wrong");
  a_stop_pins: assert property (s_reg.state == ST_HALT && s_reg.hmode == HM_STOP
      |-> !osc_en && (pins_float != s_reg.drive) && (pins_hold == s_reg.drive))
    else $error("stop pin state wrong");
  a_deep_no_wake: assert property (ce && s_reg.state == ST_HALT && s_reg.hmode == HM_OSC
      && !req_vec[`IHC_CH_NMI] && !req_vec[`IHC_CH_EXT0] |=> s_reg.state == ST_HALT)
    else $error("deep halt released by blocked source");
  a_run_release: assert property (ce && s_reg.state == ST_HALT && s_reg.hmode == HM_RUN
      && wake |=> halt_release && s_reg.state == ST_RUN && sysclk_all_en)
    else $error("run-halt release missing");

  c_stop_cycle: cover property (s_reg.state == ST_WARM ##1 halt_release);
  c_idle_wake:  cover property (s_reg.state == ST_HALT && s_reg.hmode == HM_PERIPH ##1
                                halt_release);
  c_dma_route:  cover property (|dma_route);
endmodule

// ---- common/ihc_regs.svh ----
// Behaviour
// - request latch, enable per channel, dma flag on four
// - latch cleared by reset, acknowledge, or vector write
// - pending status readable at the two status addresses
// - enable flags at first two enable addresses, reset zero
// - dma flags at second pair, reset zero
// - nmi falls, first input level/rise, second rises
// - edge to level clears flag; reverse keeps it
// - serial receive flag cleared only by reset, buffer read
// - halt mode field bits 3:2, resets to run-halt
// - run-halt keeps clocks, samples requests each edge
// - oscillator-only halt holds clock output high
// - watchdog request blocked during oscillator-only halt
// - peripheral halt clocks timers, serial, watchdog only
// - stop floats pins unless pin-hold bit set
// - stop release waits selected warm-up count
// - reset ends stop without warm-up; hold reset long
// - disabled maskable wake resumes, flag stays set; here a disabled request does not wake
// - reset out of halt keeps pre-halt memory state
// - codes 00 and 11 select the two idle modes
// - deep halts woken only by nmi, first input, reset
`ifndef IHC_REGS_SVH
`define IHC_REGS_SVH

// register addresses
`define IHC_ADDR_STAT_LO   16'hffc2
`define IHC_ADDR_STAT_CLR  16'hffc3
`define IHC_ADDR_PORT8_CTL 16'hffd1
`define IHC_ADDR_HALT_WD   16'hffd2
`define IHC_ADDR_EN_LO     16'hffe6
`define IHC_ADDR_EN_DMA    16'hffe7
`define IHC_ADDR_DMA_HI    16'hffe8

// channel indices in the request vectors
`define IHC_NCH        11
`define IHC_CH_NMI     0
`define IHC_CH_WDOG    1
`define IHC_CH_EXT0    2
`define IHC_CH_TMR0    3
`define IHC_CH_TMR1    4
`define IHC_CH_TMR2    5
`define IHC_CH_TMR3    6
`define IHC_CH_SPARE   7
`define IHC_CH_EXT1    8
`define IHC_CH_RXD     9
`define IHC_CH_TXD     10

// vector divided by eight
`define IHC_VEC_FIRST  8'h03
`define IHC_VEC_LINEAR 8'h0b
`define IHC_VEC_RXD    8'h0e
`define IHC_VEC_TXD    8'h0f

// halt/watchdog register fields and reset
`define IHC_HW_DRIVE   0
`define IHC_HW_MODE_LO 2
`define IHC_HW_WARM    4
`define IHC_HW_WD_LO   5
`define IHC_HW_WD_RST  3'h4
`define IHC_P8_EDGE    0

// warm-up counts in clock cycles
`define IHC_WARM_SHORT 16384
`define IHC_WARM_LONG  65536
`define IHC_WCNT_W     17

`endif

// ---- common/ihc_pkg.sv ----
`include "ihc_regs.svh"
package ihc_pkg;
  // halt mode codes as held in the mode field
  typedef enum logic [1:0] {
    HM_RUN    = 2'b00,
    HM_STOP   = 2'b01,
    HM_OSC    = 2'b10,
    HM_PERIPH = 2'b11
  } ihc_hmode_e;

  // halt sequencer states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_WARM = 2'b10
  } ihc_hstate_e;

  typedef logic [`IHC_NCH-1:0] ihc_chvec_t;

  // edge detector state
  typedef struct packed {
    logic prev;
  } ihc_edge_s;

  // controller state
  typedef struct packed {
    ihc_hstate_e             state;
    ihc_hmode_e              hmode;
    ihc_chvec_t              pend;
    ihc_chvec_t              en;
    ihc_chvec_t              dma;
    logic                    edge_sel;
    logic [2:0]              wd_bits;
    logic                    warm;
    logic                    drive;
    logic [`IHC_WCNT_W-1:0]  wcnt;
    logic                    release_p;
    logic [7:0]              rdata;
  } ihc_state_s;
endpackage

// ---- design/ihc_edge_det.sv ----
`timescale 1ns/10ps
module ihc_edge_det #(
  parameter bit RISING = 1'b1
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic ce,
  // sampled level and detected edge
  input  wire logic din,
  output logic      pulse
);
  import ihc_pkg::*;

  ihc_edge_s s_reg;   // previous sample
  ihc_edge_s s_next;

  // edge is a one-cycle pulse against the previous sample
  assign pulse = ce & (RISING ? (din & ~s_reg.prev) : (~din & s_reg.prev));

  // next sample, frozen while ce is low
  always_comb begin
    s_next = s_reg;
    if (ce) begin
      s_next.prev = din;
    end
  end

  // idle level chosen so no edge fires straight out of reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= RISING ? 1'b1 : 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ---- verif/ihc_cpu_model.sv ----
`timescale 1ns/10ps
// stand-in for the cpu core and the first external level source
module ihc_cpu_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // bench commands
  input  wire logic       ack_go,
  input  wire logic [7:0] ack_vec_in,
  input  wire logic       lvl_go,
  // device side
  output logic            cpu_ack,
  output logic [7:0]      cpu_ack_vec,
  output logic            ext_irq_first
);
  // ack lasts one cycle; vector goes stale-inverse outside it
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_ack       <= 1'b0;
      cpu_ack_vec   <= 8'h00;
      ext_irq_first <= 1'b0;
    end else begin
      cpu_ack     <= ack_go;
      cpu_ack_vec <= ack_go ? ack_vec_in : ~cpu_ack_vec;
      // level held until its own ack is taken, through the response
      if (lvl_go) begin
        ext_irq_first <= 1'b1;
      end else if (cpu_ack && cpu_ack_vec == 8'h05) begin
        ext_irq_first <= 1'b0;
      end
    end
  end
endmodule

// ---- verif/interrupt_and_halt_control_test.sv ----
`timescale 1ns/10ps
module interrupt_and_halt_control_test;
  import ihc_pkg::*;
  localparam int WS = 8;  // shortened warm-up
  logic clock = 0, arst_n = 0, bus_wr = 0, bus_rd = 0, nmi_pin = 1, ext2 = 0;
  logic glob = 0, ack_go = 0, lvl_go = 0;
  logic [15:0] bus_addr = 0;
  logic [7:0] bus_wdata = 0, ack_vec_in = 0, bus_rdata, r;
  logic [9:0] pv = 0;  // peripheral pulses and halt command
  logic cpu_ack, ext1, irq_req, nmi_req, cpu_halted, halt_release;
  logic [7:0] cpu_ack_vec;
  logic sys_en, per_en, osc_en, hold_clk, pins_float, wd_en, pins_hold;
  ihc_chvec_t pend_status, mp, dma;  // mp is the bench's model of the latches
  int failures = 0, n_checks = 0, cyc = 0, n;
  always #50 clock = ~clock;
  ihc_cpu_model ihc_cpu_model_inst (.clock(clock), .arst_n(arst_n), .ack_go(ack_go),
    .ack_vec_in(ack_vec_in), .lvl_go(lvl_go), .cpu_ack(cpu_ack),
    .cpu_ack_vec(cpu_ack_vec), .ext_irq_first(ext1));
  ihc_top #(.WARM_SHORT(WS), .WARM_LONG(2*WS)) ihc_top_inst (.clock(clock),
    .arst_n(arst_n), .ce(1'b1), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .nmi_pin(nmi_pin), .ext_irq_first(ext1),
    .ext_irq_second(ext2), .watchdog_irq(pv[8]), .timer_irq(pv[3:0]), .spare_irq(pv[4]),
    .serial_rx_done_irq(pv[5]), .serial_tx_done_irq(pv[6]), .serial_rx_buf_read(pv[7]),
    .global_irq_on(glob), .cpu_ack(cpu_ack), .cpu_ack_vec(cpu_ack_vec), .halt_cmd(pv[9]),
    .pend_status(pend_status), .dma_route(dma), .irq_req(irq_req), .nmi_req(nmi_req),
    .cpu_halted(cpu_halted), .halt_release(halt_release), .sysclk_all_en(sys_en),
    .periph_clk_en(per_en), .wdog_clk_en(wd_en), .osc_en(osc_en), .clk_out_hold(hold_clk),
    .pins_float(pins_float), .pins_hold(pins_hold));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // single-bit compare, padded on purpose
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask
  // bus write, strobe held across one taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1;
    @(negedge clock);
    bus_wr = 0;
  endtask
  // bus read, data registered at the taking edge
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    bus_addr = a;
    bus_rd = 1;
    @(negedge clock);
    bus_rd = 0;
    chk("rdata", {8'h0, e}, {8'h0, bus_rdata});
  endtask
  task automatic pulse(input int b);
    @(negedge clock);
    pv[b] = 1;
    @(negedge clock);
    pv[b] = 0;
  endtask
  task automatic ack(input logic [7:0] v);
    @(negedge clock);
    ack_go = 1;
    ack_vec_in = v;
    @(negedge clock);
    ack_go = 0;
    @(negedge clock);
  endtask
  task automatic lvl();
    @(negedge clock);
    lvl_go = 1;
    @(negedge clock);
    lvl_go = 0;
    @(negedge clock);
  endtask
  task automatic pc();
    chk("pend", {5'h0, mp}, {5'h0, pend_status});
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("mismatch cycles exp below %0d got %0d", 5000, cyc);
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mp = '0;
    void'($urandom(77));
    repeat (10) @(negedge clock);
    arst_n = 1;
    rd(16'hffe6, 8'h00);
    rd(16'hffe8, 8'h00);
    rd(16'hffd2, 8'h80);
    r = 8'($urandom);
    wr(16'hffe6, r);
    rd(16'hffe6, r);
    wr(16'hffe7, r);
    rd(16'hffe7, r & 8'hc1);
    wr(16'hffe8, 8'hff);
    rd(16'hffe8, 8'h03);
    wr(16'hffd2, r);
    rd(16'hffd2, r & 8'hfd);
    wr(16'hffd2, 8'h80);
    wr(16'hffe6, 8'h40);
    wr(16'hffe7, r | 8'h80);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      mp[3+i] = 1'b1;
      pc();
    end
    rd(16'hffc2, 8'h30);
    rd(16'hffc3, 8'h03);
    chk1("irq_off", 1'b0, irq_req);
    glob = 1;
    @(negedge clock);
    chk1("irq_on", 1'b1, irq_req);
    chk("dma_route", 16'h0008, {5'h0, dma});
    wr(16'hffe6, 8'h00);
    chk1("irq_dis", 1'b0, irq_req);
    chk("dma_off", 16'h0000, {5'h0, dma});
    glob = 0;
    wr(16'hffe6, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(16'hffc3, 8'h06 + i[7:0]);
      mp[3+i] = 1'b0;
      pc();
    end
    pulse(5);
    mp[9] = 1'b1;
    wr(16'hffc3, 8'h0e);
    ack(8'h0e);
    pc();
    pulse(7);
    mp[9] = 1'b0;
    pc();
    pulse(8);
    mp[1] = 1'b1;
    chk1("nmi_req", 1'b1, nmi_req);
    ack(8'h04);
    mp[1] = 1'b0;
    pc();
    nmi_pin = 0;
    @(negedge clock);
    @(negedge clock);
    nmi_pin = 1;
    mp[0] = 1'b1;
    pc();
    ack(8'h03);
    mp[0] = 1'b0;
    ext2 = 1;
    @(negedge clock);
    @(negedge clock);
    ext2 = 0;
    mp[8] = 1'b1;
    pc();
    wr(16'hffc3, 8'h0b);
    mp[8] = 1'b0;
    lvl();
    mp[2] = 1'b1;
    pc();
    ack(8'h05);
    @(negedge clock);
    mp[2] = 1'b0;
    pc();
    wr(16'hffd1, 8'h01);
    lvl();
    mp[2] = 1'b1;
    pc();
    wr(16'hffd1, 8'h00);
    chk1("edge_lvl", 1'b0, pend_status[2]);
    ack(8'h05);
    @(negedge clock);
    mp[2] = 1'b0;
    pc();
    // each halt mode: wake by timer, deep ones only by nmi; long warm-up in stop
    for (int m = 0; m < 4; m++) begin
      wr(16'hffd2, {3'b100, m[0], m[1:0], 2'b00});
      pulse(9);
      chk1("halted", 1'b1, cpu_halted);
      chk("clocks", {9'h0, (m == 0), (m == 0 || m == 3), (m == 1 || m == 2),
          (m != 1), (m == 1), (m != 1), 1'b0}, {9'h0, sys_en, per_en, hold_clk, osc_en,
          pins_float, wd_en, pins_hold});
      if (m == 2) pulse(8);
      pulse(0);
      mp[3] = 1'b1;
      if (m == 1 || m == 2) begin
        repeat (3) @(negedge clock);
        chk1("deep", 1'b1, cpu_halted);
        nmi_pin = 0;
        mp[0] = 1'b1;
      end
      n = 0;
      while (halt_release !== 1'b1 && n < 60) begin
        @(negedge clock);
        n++;
      end
      chk1("release", 1'b1, halt_release);
      chk("warm", (m == 1) ? 16'(2 * WS + 2) : (m == 2) ? 16'h2 : 16'h1, 16'(n));
      pc();
      nmi_pin = 1;
      ack(8'h03);
      wr(16'hffc3, 8'h06);
      mp = '0;
    end
    wr(16'hffd2, 8'h85);
    pulse(9);
    @(negedge clock);
    chk("pin_hold", 16'h0001, {14'h0, pins_float, pins_hold});
    arst_n = 0;
    #1;
    chk("rst_stop", 16'h0001, {14'h0, cpu_halted, osc_en});
    repeat (10) @(negedge clock);
    arst_n = 1;
    @(negedge clock);
    chk1("rst_run", 1'b0, cpu_halted);
    rd(16'hffd2, 8'h80);
    wrap_up();
  end
endmodule
